// *** hdl/aidrc_pkg.sv ***
// Shared constants for the task-file command executor: command codes,
// sector geometry, power-down timing and identify word 164 layout.
// Assumes a single 200 MHz clock.
`default_nettype none

package aidrc_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_IDLE_A = 8'h97;
    localparam logic [7:0] CMD_IDLE_B = 8'he3;
    localparam logic [7:0] CMD_IDLE_NOW_A = 8'h95;
    localparam logic [7:0] CMD_IDLE_NOW_B = 8'he1;
    localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0] CMD_READ_BUF = 8'he4;
    localparam logic [7:0] CMD_READ_DMA = 8'hc8;

    // ------------------------------------------------------------
    // Geometry and timing
    // ------------------------------------------------------------
    localparam int SECTOR_BYTES = 512;
    localparam int SECTOR_WORDS = SECTOR_BYTES / 2;
    localparam logic [8:0] MAX_SECTORS = 9'h100;
    localparam int CLK_MHZ = 200;
    localparam int PD_TICK_MS = 5;
    localparam int AUTO_SLEEP_MS = 20;
    localparam int PD_TICK_CYCLES = PD_TICK_MS * 1000 * CLK_MHZ;
    localparam logic [7:0] AUTO_SLEEP_TICKS = 8'(AUTO_SLEEP_MS / PD_TICK_MS);

    // ------------------------------------------------------------
    // Identify word 164 field positions
    // ------------------------------------------------------------
    localparam int W164_IO_LSB = 0;
    localparam int W164_MEM_LSB = 3;
    localparam int W164_UIO_LSB = 6;
    localparam int W164_UMEM_LSB = 9;
    localparam int W164_USEL_LSB = 12;
    localparam int W164_USUP_BIT = 15;
    localparam int MAX_PIO_CODE = 3;
    localparam int MAX_UDMA_CODE = 6;

    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_IDLE,
        PM_SLEEP
    } aidrc_pm_t;
endpackage : aidrc_pkg

`default_nettype wire

// *** hdl/aidrc_core.sv ***
// Task-file command executor: idle, idle immediate, initialize parameters,
// no-op, read buffer and DMA read, plus identify word 164.
// Assumes all inputs synchronous to i_clk; media delivers sector words on a
// valid/ready stream after a sector request; LBA-style linear addressing.
//
// Contract
// - Idle: busy, idle mode, interrupt, arm timer
// - Idle with zero count disables power-down
// - Without idle command, sleep after 20 ms
// - Idle immediate: idle now, ignore parameters
// - Init params stores sectors and heads-minus-one
// - Init params ignores cylinder, sector, features
// - No-op always aborts
// - Read buffer returns sector buffer contents
// - DMA read moves 1..256 sectors, zero=256
// - DMA read sets busy, fills buffer
// - DMA request held while data available
// - DMA read interrupts only at end/error
// - Completion leaves last sector address
// - Error stops at failing sector address
// - DMA read aborted in 8-bit mode
// - Word 164 bits 2:0 I/O cycle mode
// - Word 164 bits 5:3 memory cycle mode
// - Word 164 bits 8:6 I/O UDMA max
// - Word 164 bits 11:9 memory UDMA max
// - Word 164 bits 14:12 selected UDMA mode
// - Word 164 bit 15 UDMA modes supported
// - PIO read: DRQ, clear busy, interrupt
`default_nettype none

module aidrc_core
    import aidrc_pkg::*;
#(
    parameter int TICK_CYCLES = PD_TICK_CYCLES,
    parameter int FIFO_DEPTH = 2,
    parameter logic [2:0] IO_MODE_MAX = 3'h3,
    parameter logic [2:0] MEM_MODE_MAX = 3'h3,
    parameter logic UDMA_SUPPORTED = 1'b1,
    parameter logic [2:0] UDMA_IO_MAX = 3'h4,
    parameter logic [2:0] UDMA_MEM_MAX = 3'h4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Task file command
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [7:0] i_sec_count,
    input wire logic [7:0] i_sec_num,
    input wire logic [7:0] i_cyl_lo,
    input wire logic [7:0] i_cyl_hi,
    input wire logic [3:0] i_head,
    input wire logic i_xfer8_en,
    input wire logic [2:0] i_udma_sel,
    // Status and task file results
    output logic o_busy,
    output logic o_drq,
    output logic o_err,
    output logic o_abrt,
    output logic o_irq,
    output logic o_idle,
    output logic o_sleep,
    output logic [7:0] o_sec_per_trk,
    output logic [3:0] o_heads_m1,
    output logic [7:0] o_sec_num,
    output logic [7:0] o_cyl_lo,
    output logic [7:0] o_cyl_hi,
    output logic [3:0] o_head,
    output logic [15:0] o_ident_w164,
    // Host data port
    output logic o_dmareq,
    input wire logic i_dmack_n,
    input wire logic i_rd_strobe,
    output logic [15:0] o_data,
    // Media sector source
    output logic o_media_req,
    output logic [27:0] o_media_lba,
    input wire logic i_media_valid,
    input wire logic [15:0] i_media_data,
    output logic o_media_ready,
    input wire logic i_media_err
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (TICK_CYCLES < 1 || FIFO_DEPTH != 2 || int'(IO_MODE_MAX) > MAX_PIO_CODE ||
        int'(MEM_MODE_MAX) > MAX_PIO_CODE || int'(UDMA_IO_MAX) > MAX_UDMA_CODE ||
        int'(UDMA_MEM_MAX) > MAX_UDMA_CODE) begin : g_bad_param
        $error("aidrc_core: unsupported parameter value");
    end

    typedef enum logic [1:0] {
        ST_READY,
        ST_EXEC,
        ST_DMA,
        ST_PIO
    } aidrc_state_t;

    // ------------------------------------------------------------
    // Identify word 164
    // ------------------------------------------------------------
    always_comb begin
        o_ident_w164 = 16'h0000;
        o_ident_w164[W164_IO_LSB +: 3] = IO_MODE_MAX;
        o_ident_w164[W164_MEM_LSB +: 3] = MEM_MODE_MAX;
        o_ident_w164[W164_USUP_BIT] = UDMA_SUPPORTED;
        if (UDMA_SUPPORTED) begin
            o_ident_w164[W164_UIO_LSB +: 3] = UDMA_IO_MAX;
            o_ident_w164[W164_UMEM_LSB +: 3] = UDMA_MEM_MAX;
            o_ident_w164[W164_USEL_LSB +: 3] = (i_udma_sel == 3'h7) ? 3'h0 : i_udma_sel;
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic fifo_wr_ptr_reg, fifo_wr_ptr_next;
    logic fifo_rd_ptr_reg, fifo_rd_ptr_next;
    logic [1:0] fifo_cnt_reg, fifo_cnt_next;
    logic fifo_push, fifo_pop, fifo_full, fifo_empty;
    logic [15:0] fifo_in;

    assign fifo_full = (fifo_cnt_reg == 2'(FIFO_DEPTH));
    assign fifo_empty = (fifo_cnt_reg == 2'h0);
    assign o_data = fifo_mem[fifo_rd_ptr_reg];

    always_comb begin
        fifo_wr_ptr_next = fifo_wr_ptr_reg ^ fifo_push;
        fifo_rd_ptr_next = fifo_rd_ptr_reg ^ fifo_pop;
        fifo_cnt_next = fifo_cnt_reg + 2'(fifo_push) - 2'(fifo_pop);
        // Words stranded by a failed read must not reach the next command
        if (!o_busy && !o_drq) begin
            fifo_rd_ptr_next = fifo_wr_ptr_reg;
            fifo_cnt_next = 2'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fifo_wr_ptr_reg <= 1'b0;
            fifo_rd_ptr_reg <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            fifo_wr_ptr_reg <= fifo_wr_ptr_next;
            fifo_rd_ptr_reg <= fifo_rd_ptr_next;
            fifo_cnt_reg <= fifo_cnt_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (fifo_push) begin
            fifo_mem[fifo_wr_ptr_reg] <= fifo_in;
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    aidrc_state_t state_reg, state_next;
    logic [27:0] lba_reg, lba_next;
    logic [8:0] remain_reg, remain_next;
    logic [7:0] word_idx_reg, word_idx_next;
    logic [8:0] pio_left_reg, pio_left_next;
    logic [7:0] spt_reg, spt_next;
    logic [3:0] hm1_reg, hm1_next;
    logic busy_reg, busy_next, drq_reg, drq_next;
    logic err_reg, err_next, abrt_reg, abrt_next, irq_reg, irq_next;
    logic req_reg, req_next, dma_mode;
    logic cmd_take, host_pop, sec_done, media_take;
    logic idle_cmd, idle_now_cmd;
    logic [15:0] sec_buf [SECTOR_WORDS];

    always_ff @(posedge i_clk) begin
        if (media_take) begin
            sec_buf[word_idx_reg] <= i_media_data;
        end
    end

    assign cmd_take = i_cmd_valid && (state_reg == ST_READY);
    assign idle_cmd = (i_cmd_code == CMD_IDLE_A) || (i_cmd_code == CMD_IDLE_B);
    assign idle_now_cmd = (i_cmd_code == CMD_IDLE_NOW_A) || (i_cmd_code == CMD_IDLE_NOW_B);
    assign dma_mode = (state_reg == ST_DMA);
    // DMA words need acknowledge plus strobe, PIO words only the strobe
    assign host_pop = !fifo_empty && i_rd_strobe && (dma_mode ? !i_dmack_n : (state_reg == ST_PIO));
    assign o_dmareq = dma_mode && !fifo_empty;
    assign media_take = dma_mode && req_reg && i_media_valid && !fifo_full && !i_media_err;
    assign o_media_ready = dma_mode && req_reg && !fifo_full;
    assign sec_done = media_take && (word_idx_reg == 8'(SECTOR_WORDS - 1));
    assign fifo_pop = host_pop;
    assign fifo_push = media_take || ((state_reg == ST_PIO) && pio_left_reg != 9'h0 && !fifo_full);
    assign fifo_in = media_take ? i_media_data : sec_buf[word_idx_reg];

    always_comb begin
        state_next = state_reg;
        lba_next = lba_reg;
        remain_next = remain_reg;
        word_idx_next = word_idx_reg;
        pio_left_next = pio_left_reg;
        spt_next = spt_reg;
        hm1_next = hm1_reg;
        busy_next = busy_reg;
        drq_next = drq_reg;
        err_next = err_reg;
        abrt_next = abrt_reg;
        irq_next = 1'b0;
        req_next = req_reg;
        unique case (state_reg)
            ST_READY: begin
                if (cmd_take) begin
                    busy_next = 1'b1;
                    err_next = 1'b0;
                    abrt_next = 1'b0;
                    state_next = ST_EXEC;
                    if (i_cmd_code == CMD_INIT_PARAMS) begin
                        spt_next = i_sec_count;
                        hm1_next = i_head;
                    end else if (i_cmd_code == CMD_READ_DMA && !i_xfer8_en) begin
                        lba_next = {i_head, i_cyl_hi, i_cyl_lo, i_sec_num};
                        remain_next = (i_sec_count == 8'h00) ? MAX_SECTORS : {1'b0, i_sec_count};
                        word_idx_next = 8'h00;
                        req_next = 1'b1;
                        state_next = ST_DMA;
                    end else if (i_cmd_code == CMD_READ_BUF) begin
                        word_idx_next = 8'h00;
                        pio_left_next = 9'(SECTOR_WORDS);
                        busy_next = 1'b0;
                        drq_next = 1'b1;
                        irq_next = 1'b1;
                        state_next = ST_PIO;
                    end else if (!(idle_cmd || idle_now_cmd)) begin
                        // No-op, 8-bit DMA read and unknown codes abort
                        abrt_next = 1'b1;
                        err_next = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                busy_next = 1'b0;
                irq_next = 1'b1;
                state_next = ST_READY;
            end
            ST_DMA: begin
                if (i_media_err && req_reg) begin
                    // Address stays on the failing sector
                    req_next = 1'b0;
                    err_next = 1'b1;
                    busy_next = 1'b0;
                    drq_next = 1'b0;
                    irq_next = 1'b1;
                    state_next = ST_READY;
                end else begin
                    if (media_take) begin
                        word_idx_next = word_idx_reg + 8'h01;
                    end
                    if (!fifo_empty) begin
                        busy_next = 1'b0;
                        drq_next = 1'b1;
                    end
                    if (sec_done) begin
                        remain_next = remain_reg - 9'h001;
                        if (remain_reg == 9'h001) begin
                            req_next = 1'b0;
                        end else begin
                            lba_next = lba_reg + 28'h0000001;
                        end
                    end
                    // Only the last word leaving ends the command
                    if (!req_reg && fifo_cnt_next == 2'h0) begin
                        drq_next = 1'b0;
                        busy_next = 1'b0;
                        irq_next = 1'b1;
                        state_next = ST_READY;
                    end
                end
            end
            ST_PIO: begin
                if (fifo_push) begin
                    word_idx_next = word_idx_reg + 8'h01;
                    pio_left_next = pio_left_reg - 9'h001;
                end
                if (pio_left_reg == 9'h0 && fifo_cnt_next == 2'h0) begin
                    drq_next = 1'b0;
                    state_next = ST_READY;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_READY;
            lba_reg <= 28'h0000000;
            remain_reg <= 9'h000;
            word_idx_reg <= 8'h00;
            pio_left_reg <= 9'h000;
            spt_reg <= 8'h00;
            hm1_reg <= 4'h0;
            busy_reg <= 1'b0;
            drq_reg <= 1'b0;
            err_reg <= 1'b0;
            abrt_reg <= 1'b0;
            irq_reg <= 1'b0;
            req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lba_reg <= lba_next;
            remain_reg <= remain_next;
            word_idx_reg <= word_idx_next;
            pio_left_reg <= pio_left_next;
            spt_reg <= spt_next;
            hm1_reg <= hm1_next;
            busy_reg <= busy_next;
            drq_reg <= drq_next;
            err_reg <= err_next;
            abrt_reg <= abrt_next;
            irq_reg <= irq_next;
            req_reg <= req_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_drq = drq_reg;
    assign o_err = err_reg;
    assign o_abrt = abrt_reg;
    assign o_irq = irq_reg;
    assign o_sec_per_trk = spt_reg;
    assign o_heads_m1 = hm1_reg;
    assign {o_head, o_cyl_hi, o_cyl_lo, o_sec_num} = lba_reg;
    assign o_media_req = req_reg;
    assign o_media_lba = lba_reg;

    // ------------------------------------------------------------
    // Power-down timer
    // ------------------------------------------------------------
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [7:0] pd_load_reg, pd_load_next, pd_cnt_reg, pd_cnt_next;
    logic pd_en_reg, pd_en_next;
    aidrc_pm_t pm_reg, pm_next;
    logic tick;

    assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

    always_comb begin
        tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
        pd_load_next = pd_load_reg;
        pd_en_next = pd_en_reg;
        pd_cnt_next = pd_cnt_reg;
        pm_next = pm_reg;
        if (cmd_take) begin
            tick_cnt_next = '0;
            pd_cnt_next = pd_load_reg;
            pm_next = PM_ACTIVE;
            if (idle_cmd) begin
                pm_next = PM_IDLE;
                pd_en_next = (i_sec_count != 8'h00);
                pd_load_next = i_sec_count;
                pd_cnt_next = i_sec_count;
            end else if (idle_now_cmd) begin
                pm_next = PM_IDLE;
            end
        end else if (pd_en_reg && pm_reg != PM_SLEEP && state_reg == ST_READY && tick) begin
            if (pd_cnt_reg <= 8'h01) begin
                pm_next = PM_SLEEP;
                pd_cnt_next = 8'h00;
            end else begin
                pd_cnt_next = pd_cnt_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_reg <= '0;
            pd_load_reg <= AUTO_SLEEP_TICKS;
            pd_cnt_reg <= AUTO_SLEEP_TICKS;
            pd_en_reg <= 1'b1;
            pm_reg <= PM_ACTIVE;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            pd_load_reg <= pd_load_next;
            pd_cnt_reg <= pd_cnt_next;
            pd_en_reg <= pd_en_next;
            pm_reg <= pm_next;
        end
    end

    assign o_idle = (pm_reg == PM_IDLE);
    assign o_sleep = (pm_reg == PM_SLEEP);
endmodule : aidrc_core

`default_nettype wire

// *** test/aidrc_core_assertions.sv ***
// Concurrent checks on the command executor's ports.
// Assumes one clock domain and an active-high asynchronous reset.
`default_nettype none

module aidrc_core_chk
    import aidrc_pkg::*;
#(
    parameter logic UDMA_SUPPORTED = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Command inputs
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [7:0] i_sec_count,
    input wire logic [7:0] i_sec_num,
    input wire logic [7:0] i_cyl_lo,
    input wire logic [7:0] i_cyl_hi,
    input wire logic [3:0] i_head,
    input wire logic i_xfer8_en,
    input wire logic [2:0] i_udma_sel,
    input wire logic i_media_err,
    // Design outputs
    input wire logic o_busy,
    input wire logic o_drq,
    input wire logic o_err,
    input wire logic o_abrt,
    input wire logic o_irq,
    input wire logic o_idle,
    input wire logic o_sleep,
    input wire logic [7:0] o_sec_per_trk,
    input wire logic [3:0] o_heads_m1,
    input wire logic [15:0] o_ident_w164,
    input wire logic o_dmareq,
    input wire logic o_media_req,
    input wire logic [27:0] o_media_lba
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic cmd_taken;
    assign cmd_taken = i_cmd_valid && !o_busy && !o_drq && !o_dmareq;

    init_store_a: assert property (cmd_taken && i_cmd_code == CMD_INIT_PARAMS |=> o_busy
        && o_sec_per_trk == $past(i_sec_count) && o_heads_m1 == $past(i_head) ##1 o_irq && !o_busy)
        else $error("init not stored");
    idle_enter_a: assert property (cmd_taken && i_cmd_code inside {8'h97, 8'he3, 8'h95, 8'he1}
        |-> ##2 o_irq && o_idle && !o_err) else $error("idle not done");
    nop_abort_a: assert property (cmd_taken && i_cmd_code == CMD_NOP |-> ##2 o_irq && o_err && o_abrt)
        else $error("no-op did not abort");
    byte_mode_a: assert property (cmd_taken && i_cmd_code == CMD_READ_DMA && i_xfer8_en
        |=> !o_media_req ##1 o_irq && o_abrt) else $error("byte mode not aborted");
    dma_start_a: assert property (cmd_taken && i_cmd_code == CMD_READ_DMA && !i_xfer8_en
        |=> o_busy && o_media_req && o_media_lba == {$past(i_head), $past(i_cyl_hi), $past(i_cyl_lo), $past(i_sec_num)})
        else $error("dma read start wrong");
    dma_quiet_a: assert property (o_dmareq |-> !o_irq) else $error("interrupt during dma data");
    media_fail_a: assert property (o_media_req && i_media_err |=> o_err && o_irq && !o_media_req)
        else $error("media error not reported");
    buf_read_a: assert property (cmd_taken && i_cmd_code == CMD_READ_BUF |=> o_drq && o_irq && !o_busy)
        else $error("read buffer start wrong");
    ident_sel_a: assert property (o_ident_w164[15] == UDMA_SUPPORTED && (!UDMA_SUPPORTED
        || o_ident_w164[14:12] == (i_udma_sel == 3'h7 ? 3'h0 : i_udma_sel))) else $error("identify word wrong");
    sleep_ready_a: assert property (o_sleep |-> !o_busy && !o_drq) else $error("asleep while busy");

    cover property (o_sleep);
    cover property (o_media_req && i_media_err);
    cover property (o_irq && !o_err && $past(o_dmareq));
endmodule : aidrc_core_chk

bind aidrc_core aidrc_core_chk #(.UDMA_SUPPORTED(UDMA_SUPPORTED)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
    .i_sec_count(i_sec_count), .i_sec_num(i_sec_num), .i_cyl_lo(i_cyl_lo), .i_cyl_hi(i_cyl_hi),
    .i_head(i_head), .i_xfer8_en(i_xfer8_en), .i_udma_sel(i_udma_sel), .i_media_err(i_media_err),
    .o_busy(o_busy), .o_drq(o_drq), .o_err(o_err), .o_abrt(o_abrt), .o_irq(o_irq), .o_idle(o_idle),
    .o_sleep(o_sleep), .o_sec_per_trk(o_sec_per_trk), .o_heads_m1(o_heads_m1), .o_ident_w164(o_ident_w164),
    .o_dmareq(o_dmareq), .o_media_req(o_media_req), .o_media_lba(o_media_lba)
);

`default_nettype wire

// *** test/aidrc_media_model.sv ***
// Media sector source: 256 words per requested sector, word = {lba[7:0], index}.
// Assumes the core holds the address steady within a sector; can run slow or fail.
`default_nettype none

module aidrc_media_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Core side
    input wire logic i_req,
    input wire logic [27:0] i_lba,
    input wire logic i_ready,
    output logic o_valid,
    output logic [15:0] o_data,
    output logic o_err,
    // Test controls
    input wire logic i_slow,
    input wire logic i_fail_en,
    input wire logic [27:0] i_fail_lba
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] idx_reg;
    logic phase_reg;

    // Slow mode holds each word until taken, then idles one cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_reg <= 8'h00;
            phase_reg <= 1'b0;
        end else begin
            if (!o_valid || i_ready) phase_reg <= !phase_reg;
            if (!i_req) idx_reg <= 8'h00;
            else if (o_valid && i_ready) idx_reg <= idx_reg + 8'h01;
        end
    end

    assign o_valid = i_req && (!i_slow || phase_reg);
    // Data is inverted whenever nothing is offered
    assign o_data = o_valid ? {i_lba[7:0], idx_reg} : ~{i_lba[7:0], idx_reg};
    assign o_err = i_req && i_fail_en && i_lba == i_fail_lba && idx_reg == 8'h20;
endmodule : aidrc_media_model

`default_nettype wire

// *** test/tb_ata_idle_dma_read_cmds.sv ***
// Self-checking bench for the command executor.
// Assumes the media model beside it; power tick shortened to 10 cycles.
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_ata_idle_dma_read_cmds import aidrc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, xfer8 = 1'b0, dmack_n = 1'b1, rd_strobe = 1'b0;
    logic [7:0] cmd_code = 8'h00, sec_count = 8'h00, sec_num = 8'h00, cyl_lo = 8'h00, cyl_hi = 8'h00;
    logic [3:0] head = 4'h0;
    logic [2:0] udma_sel = 3'h0;
    logic slow = 1'b0, fail_en = 1'b0;
    logic [27:0] fail_lba = 28'h0000051;
    logic busy, drq, err, abrt, irq, idle, sleep, dmareq, m_req, m_ready, m_valid, m_err;
    logic [7:0] spt, o_sn, o_cl, o_ch;
    logic [3:0] hm1, o_hd;
    logic [15:0] w164, data, m_data;
    logic [27:0] m_lba;
    int failures = 0;
    int samples_checked = 0;

    always #2.5 clk = ~clk;

    aidrc_core #(.TICK_CYCLES(10), .IO_MODE_MAX(3'h3), .MEM_MODE_MAX(3'h2),
        .UDMA_IO_MAX(3'h6), .UDMA_MEM_MAX(3'h5)) dut (
        .i_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_sec_count(sec_count),
        .i_sec_num(sec_num), .i_cyl_lo(cyl_lo), .i_cyl_hi(cyl_hi), .i_head(head), .i_xfer8_en(xfer8),
        .i_udma_sel(udma_sel), .o_busy(busy), .o_drq(drq), .o_err(err), .o_abrt(abrt), .o_irq(irq),
        .o_idle(idle), .o_sleep(sleep), .o_sec_per_trk(spt), .o_heads_m1(hm1), .o_sec_num(o_sn),
        .o_cyl_lo(o_cl), .o_cyl_hi(o_ch), .o_head(o_hd), .o_ident_w164(w164), .o_dmareq(dmareq),
        .i_dmack_n(dmack_n), .i_rd_strobe(rd_strobe), .o_data(data), .o_media_req(m_req), .o_media_lba(m_lba),
        .i_media_valid(m_valid), .i_media_data(m_data), .o_media_ready(m_ready), .i_media_err(m_err));

    aidrc_media_model media (.i_clk(clk), .i_rst(rst), .i_req(m_req), .i_lba(m_lba), .i_ready(m_ready),
        .o_valid(m_valid), .o_data(m_data), .o_err(m_err), .i_slow(slow), .i_fail_en(fail_en),
        .i_fail_lba(fail_lba));

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic cmd(input logic [7:0] code, input logic [7:0] cnt, input logic [27:0] lba);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        sec_count <= cnt;
        {head, cyl_hi, cyl_lo, sec_num} <= lba;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : cmd

    task automatic simple(input logic [7:0] code, input logic [7:0] cnt, input logic [27:0] lba, input logic ab);
        cmd(code, cnt, lba);
        #1 `CHK(busy, 1'b1)
        @(posedge clk);
        #1 `CHK({irq, busy, err, abrt}, {1'b1, 1'b0, ab, ab})
    endtask : simple

    // Host side: acknowledge held for DMA only, one strobe per word, stalls in slow runs
    task automatic xfer(input logic pio, input logic [27:0] base, input int lim, output int nw, output int ni);
        int k;
        logic [27:0] s;
        nw = 0;
        ni = 0;
        dmack_n <= pio;
        for (k = 0; k < 70000; k++) begin
            @(posedge clk);
            ni += int'(irq === 1'b1);
            if (rd_strobe && (pio ? drq === 1'b1 : dmareq === 1'b1 && !dmack_n)) begin
                s = base + 28'(nw / 256);
                `CHK(data, {s[7:0], 8'(nw)})
                nw++;
            end
            rd_strobe <= (!slow || k % 5 != 4) && nw < lim;
            if (k > 2 && !busy && !drq && !dmareq) break;
        end
        if (k == 70000) begin
            failures++;
            conclude();
        end
        rd_strobe <= 1'b0;
        dmack_n <= 1'b1;
    endtask : xfer

    task automatic dma(input logic [7:0] cnt, input logic [27:0] lba, input int nexp, input logic e);
        int nw, ni;
        logic [27:0] last;
        last = e ? fail_lba : lba + 28'(nexp / 256) - 28'h1;
        cmd(CMD_READ_DMA, cnt, lba);
        xfer(1'b0, lba, nexp, nw, ni);
        if (!e) `CHK(nw, nexp)
        `CHK(ni, 1)
        `CHK({o_hd, o_ch, o_cl, o_sn}, last)
        `CHK({err, abrt}, {e, 1'b0})
        $display("dma read of %0d words done", nw);
    endtask : dma

    task automatic t_buffer(input logic [27:0] lba);
        int nw, ni;
        cmd(CMD_READ_BUF, 8'h00, 28'h0);
        xfer(1'b1, lba, 256, nw, ni);
        `CHK(nw, 256)
        `CHK(ni, 1)
        $display("read buffer done");
    endtask : t_buffer

    task automatic t_power;
        int k;
        repeat (30) @(posedge clk);
        #1 `CHK(sleep, 1'b0)
        for (k = 0; k < 40 && sleep !== 1'b1; k++) @(posedge clk);
        #1 `CHK(sleep, 1'b1)
        simple(CMD_IDLE_A, 8'h02, 28'h0, 1'b0);
        `CHK({idle, sleep}, 2'b10)
        repeat (10) @(posedge clk);
        #1 `CHK(sleep, 1'b0)
        for (k = 0; k < 30 && sleep !== 1'b1; k++) @(posedge clk);
        #1 `CHK(sleep, 1'b1)
        simple(CMD_IDLE_B, 8'h00, 28'hfffffff, 1'b0);
        simple(CMD_IDLE_NOW_A, 8'h05, 28'hfffffff, 1'b0);
        simple(CMD_IDLE_NOW_B, 8'h05, 28'h0, 1'b0);
        `CHK(idle, 1'b1)
        repeat (100) @(posedge clk);
        #1 `CHK({idle, sleep}, 2'b10)
        $display("power commands done");
    endtask : t_power

    task automatic t_simple;
        simple(CMD_NOP, 8'h00, 28'h0, 1'b1);
        simple(CMD_INIT_PARAMS, 8'h3f, 28'h5a5c33c, 1'b0);
        `CHK({spt, hm1}, {8'h3f, 4'h5})
        simple(CMD_INIT_PARAMS, 8'hc0, 28'ha000000, 1'b0);
        `CHK({spt, hm1}, {8'hc0, 4'ha})
        @(posedge clk);
        xfer8 <= 1'b1;
        simple(CMD_READ_DMA, 8'h01, 28'h0, 1'b1);
        @(posedge clk);
        xfer8 <= 1'b0;
        $display("simple commands done");
    endtask : t_simple

    task automatic t_ident;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            udma_sel <= 3'(s);
            @(posedge clk);
            #1 `CHK(w164, {1'b1, 3'(s % 7), 12'hb93})
        end
        $display("identify word done");
    endtask : t_ident

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_simple();
        t_ident();
        slow <= 1'b1;
        dma(8'h02, 28'h12345ff, 512, 1'b0);
        t_buffer(28'h1234600);
        slow <= 1'b0;
        dma(8'h00, 28'h0000100, 65536, 1'b0);
        fail_en <= 1'b1;
        dma(8'h03, 28'h0000050, 768, 1'b1);
        conclude();
    end
endmodule : tb_ata_idle_dma_read_cmds

`default_nettype wire
